// ---- pkg/nvc_pkg.sv ----
package nvc_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned NV_BYTES = 15;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned LEVEL_W  = 6;
  localparam int unsigned PUMP_BIT = 6;
  localparam int unsigned FAULT_W  = 4;

  // register map
  localparam logic [7:0] ADDR_WORK_FIRST  = 8'h07;
  localparam logic [7:0] ADDR_WORK_LAST   = 8'h15;
  localparam logic [7:0] ADDR_NV_FIRST    = 8'h17;
  localparam logic [7:0] ADDR_NV_LAST     = 8'h25;
  localparam logic [7:0] ADDR_CMD_COMMIT  = 8'h78;
  localparam logic [7:0] ADDR_CMD_RELOAD  = 8'h79;
  localparam logic [7:0] ADDR_CMD_RESTART = 8'h7A;

  // byte positions inside the 15-byte banks
  localparam logic [3:0] IDX_FIRST     = 4'h0;
  localparam logic [3:0] IDX_LAST      = 4'hE;
  localparam logic [3:0] IDX_RAIL_POS  = 4'hC;
  localparam logic [3:0] IDX_GATE_HIGH = 4'hD;
  localparam logic [3:0] IDX_GATE_LOW  = 4'hE;

  localparam logic [7:0] LEVEL_MASK = 8'h3F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  localparam logic [2:0] COMMIT_LIMIT = 3'h6;
  localparam logic [2:0] COUNT_STEP   = 3'h1;

  // programming time in its own unit, then in clock cycles
  localparam int unsigned COMMIT_TIME_MS = 20;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned COMMIT_CYCLES  = COMMIT_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    NVC_BOOT,
    NVC_IDLE,
    NVC_COPY,
    NVC_WAIT
  } nvc_state_t;

  // address window test, used for both banks
  function automatic logic nvc_in_range(input logic [7:0] a,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

// ---- rtl/nvc_byte_bank.sv ----
`timescale 1ns/10ps
module nvc_byte_bank #(
  parameter int unsigned N = 15
) (
  input  wire logic                        mclk,      // system clock
  input  wire logic                        rst_n,     // async reset, active low
  input  wire logic                        ce,        // clock enable
  input  wire logic                        wr_en,     // single byte write
  input  wire logic [nvc_pkg::IDX_W-1:0]   wr_idx,    // byte index
  input  wire logic [nvc_pkg::DATA_W-1:0]  wr_data,   // byte value
  input  wire logic                        load_all,  // whole-bank load
  input  wire logic [N*nvc_pkg::DATA_W-1:0] load_data, // bank image in
  output logic      [N*nvc_pkg::DATA_W-1:0] q          // bank image out
);
  import nvc_pkg::*;

  logic [DATA_W-1:0] mem_reg [N];

  // flatten the flops for the wide image
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_out
      assign q[g*DATA_W +: DATA_W] = mem_reg[g];
    end
  endgenerate

  // whole-bank load wins over a single byte write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) mem_reg[i] <= RESET_BYTE;
    end else if (ce) begin
      if (load_all) begin
        for (int i = 0; i < N; i++) mem_reg[i] <= load_data[i*DATA_W +: DATA_W];
      end else if (wr_en) begin
        mem_reg[wr_idx] <= wr_data;
      end
    end
  end
endmodule // nvc_byte_bank

// ---- rtl/nvc_prog_timer.sv ----
`timescale 1ns/10ps
module nvc_prog_timer #(
  parameter int unsigned CNT_W = 19
) (
  input  wire logic             mclk,       // system clock
  input  wire logic             rst_n,      // async reset, active low
  input  wire logic             ce,         // clock enable
  input  wire logic             start,      // load the count
  input  wire logic [CNT_W-1:0] load_value, // cycles to wait, at least one
  output logic                  busy,       // count still running
  output logic                  done        // one-cycle pulse after expiry
);
  logic [CNT_W-1:0] cnt_reg;
  logic             done_reg;
  wire logic        last_tick;

  assign last_tick = (cnt_reg == CNT_W'(1));
  assign busy      = (cnt_reg != '0);
  assign done      = done_reg;

  // down counter; a zero load would never raise done, so callers avoid it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= busy && last_tick;
      if (start) begin
        cnt_reg <= load_value;
      end else if (busy) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
    end
  end
endmodule // nvc_prog_timer

// ---- rtl/nvc_top.sv ----
`timescale 1ns/10ps
module nvc_top #(
  parameter int unsigned COMMIT_CYCLES = nvc_pkg::COMMIT_CYCLES
) (
  input  wire logic                         mclk,               // 20 MHz clock
  input  wire logic                         rst_n,              // async reset, active low
  input  wire logic                         ce,                 // clock enable
  input  wire logic                         reg_wr,             // register write strobe
  input  wire logic                         reg_rd,             // register read strobe
  input  wire logic [nvc_pkg::ADDR_W-1:0]   reg_addr,           // register address
  input  wire logic [nvc_pkg::DATA_W-1:0]   reg_wdata,          // write data
  output logic      [nvc_pkg::DATA_W-1:0]   reg_rdata,          // read data, registered
  input  wire logic                         vprog_ok,           // programming supply good
  input  wire logic [nvc_pkg::FAULT_W-1:0]  fault_event,        // fault detector pulses
  output logic      [nvc_pkg::FAULT_W-1:0]  fault_flags,        // sticky fault record
  output logic                              latched_fault_mode, // outputs held off
  output logic                              restart_pulse,      // restart accepted
  output logic                              nvm_busy,           // commit or boot reload in progress
  output logic                              nvm_write_fail_flag, // last commit failed
  output logic      [nvc_pkg::LEVEL_W-1:0]  positive_rail_level, // positive analog rail
  output logic      [nvc_pkg::LEVEL_W-1:0]  negative_rail_level, // negative analog rail
  output logic      [nvc_pkg::LEVEL_W-1:0]  gate_high_level,     // gate-high rail
  output logic      [nvc_pkg::LEVEL_W-1:0]  gate_low_level,      // gate-low rail
  output logic                              pump_stage_select    // doubler instead of tripler
);
  import nvc_pkg::*;

  localparam int unsigned TMR_W = $clog2(COMMIT_CYCLES + 1);
  localparam int unsigned BANK_W = NV_BYTES * DATA_W;

  nvc_state_t        state_reg, state_next;
  logic [IDX_W-1:0]  copy_idx_reg;
  logic [2:0]        commit_cnt_reg;
  logic              fail_reg;
  logic [FAULT_W-1:0] fault_reg;
  logic              fault_mode_reg;
  logic              restart_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [BANK_W-1:0] work_q;
  logic [BANK_W-1:0] nv_q;
  logic [DATA_W-1:0] work_b [NV_BYTES];
  logic [DATA_W-1:0] nv_b   [NV_BYTES];
  logic              tmr_done;

  // byte views of both banks
  genvar g;
  generate
    for (g = 0; g < NV_BYTES; g++) begin : g_bytes
      assign work_b[g] = work_q[g*DATA_W +: DATA_W];
      assign nv_b[g]   = nv_q[g*DATA_W +: DATA_W];
    end
  endgenerate

  // write acceptance: nothing but idle takes a write, so a commit is never torn
  wire logic idle_st     = (state_reg == NVC_IDLE);
  wire logic wr_ok       = ce && reg_wr && idle_st;
  wire logic hit_commit  = wr_ok && (reg_addr == ADDR_CMD_COMMIT);
  wire logic hit_reload  = wr_ok && (reg_addr == ADDR_CMD_RELOAD);
  wire logic hit_restart = wr_ok && (reg_addr == ADDR_CMD_RESTART);
  wire logic hit_work    = wr_ok && nvc_in_range(reg_addr, ADDR_WORK_FIRST, ADDR_WORK_LAST);
  wire logic [IDX_W-1:0] work_widx = IDX_W'(reg_addr - ADDR_WORK_FIRST);

  // a spent store or a missing programming supply fails at once
  wire logic limit_hit   = (commit_cnt_reg == COMMIT_LIMIT);
  wire logic commit_go   = hit_commit && !limit_hit && vprog_ok;
  wire logic commit_bad  = hit_commit && !commit_go;
  wire logic copy_st     = (state_reg == NVC_COPY);
  wire logic copy_last   = (copy_idx_reg == IDX_LAST);
  wire logic boot_st     = (state_reg == NVC_BOOT);
  wire logic prog_lost   = (copy_st || (state_reg == NVC_WAIT)) && !vprog_ok;

  // stored gate-low byte keeps only its six level bits
  wire logic [DATA_W-1:0] copy_byte = (copy_idx_reg == IDX_GATE_LOW) ?
                                      (work_b[copy_idx_reg] & LEVEL_MASK) :
                                      work_b[copy_idx_reg];

  // read decode; command registers and holes read zero
  wire logic rd_work = nvc_in_range(reg_addr, ADDR_WORK_FIRST, ADDR_WORK_LAST);
  wire logic rd_nv   = nvc_in_range(reg_addr, ADDR_NV_FIRST, ADDR_NV_LAST);
  wire logic [IDX_W-1:0] nv_ridx = IDX_W'(reg_addr - ADDR_NV_FIRST);
  wire logic [DATA_W-1:0] rd_value = rd_work ? work_b[work_widx] :
                                     rd_nv   ? nv_b[nv_ridx] : READ_ZERO;

  nvc_byte_bank #(
    .N (NV_BYTES)
  ) u_work (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .ce        (ce),
    .wr_en     (hit_work),
    .wr_idx    (work_widx),
    .wr_data   (reg_wdata),
    .load_all  (hit_reload || boot_st),
    .load_data (nv_q),
    .q         (work_q)
  );

  nvc_byte_bank #(
    .N (NV_BYTES)
  ) u_store (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .ce        (ce),
    .wr_en     (copy_st),
    .wr_idx    (copy_idx_reg),
    .wr_data   (copy_byte),
    .load_all  (1'b0),
    .load_data ('0),
    .q         (nv_q)
  );

  nvc_prog_timer #(
    .CNT_W (TMR_W)
  ) u_timer (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ce         (ce),
    .start      (copy_st && copy_last),
    .load_value (TMR_W'(COMMIT_CYCLES)),
    .busy       (),
    .done       (tmr_done)
  );

  // sequencer: boot reload, byte-wise copy, then programming wait
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      NVC_BOOT: state_next = NVC_IDLE;
      NVC_IDLE: if (commit_go) state_next = NVC_COPY;
      NVC_COPY: if (copy_last) state_next = NVC_WAIT;
      NVC_WAIT: if (tmr_done) state_next = NVC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= NVC_BOOT;
      copy_idx_reg <= IDX_FIRST;
    end else if (ce) begin
      state_reg    <= state_next;
      copy_idx_reg <= copy_st ? IDX_W'(copy_idx_reg + 1'b1) : IDX_FIRST;
    end
  end

  // lifetime count saturates; an attempt that reaches the cells uses one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      commit_cnt_reg <= '0;
    end else if (ce && commit_go) begin
      commit_cnt_reg <= commit_cnt_reg + COUNT_STEP;
    end
  end

  // fail flag reflects the latest commit only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fail_reg <= 1'b0;
    end else if (ce) begin
      if (commit_bad || prog_lost) fail_reg <= 1'b1;
      else if (commit_go) fail_reg <= 1'b0;
    end
  end

  // faults: a new event beats a restart in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg      <= '0;
      fault_mode_reg <= 1'b0;
      restart_reg    <= 1'b0;
    end else if (ce) begin
      fault_reg      <= (hit_restart ? '0 : fault_reg) | fault_event;
      fault_mode_reg <= (fault_mode_reg && !hit_restart) || (|fault_event);
      restart_reg    <= hit_restart;
    end
  end

  // read data held until the next read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= RESET_BYTE;
    end else if (ce && reg_rd) begin
      rdata_reg <= rd_value;
    end
  end

  // rail settings come straight from working flops
  assign positive_rail_level = work_b[IDX_RAIL_POS][LEVEL_W-1:0];
  assign negative_rail_level = work_b[IDX_RAIL_POS][LEVEL_W-1:0];
  assign gate_high_level     = work_b[IDX_GATE_HIGH][LEVEL_W-1:0];
  assign pump_stage_select   = work_b[IDX_GATE_HIGH][PUMP_BIT];
  assign gate_low_level      = work_b[IDX_GATE_LOW][LEVEL_W-1:0];

  assign reg_rdata           = rdata_reg;
  assign fault_flags         = fault_reg;
  assign latched_fault_mode  = fault_mode_reg;
  assign restart_pulse       = restart_reg;
  assign nvm_busy            = !idle_st;
  assign nvm_write_fail_flag = fail_reg;

  // checks next to the logic they guard
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  rail_mirror_a: assert property (
    negative_rail_level == positive_rail_level)
    else $error("negative rail differs from positive rail");

  store_top_bits_a: assert property (
    ce && reg_rd && (reg_addr == ADDR_NV_LAST)
    |=> reg_rdata[DATA_W-1:LEVEL_W] == '0)
    else $error("stored gate-low byte shows upper bits");

  commit_copy_a: assert property (
    ce && copy_st |=> nv_b[$past(copy_idx_reg)] == $past(copy_byte))
    else $error("commit did not copy the working byte");

  reload_image_a: assert property (
    hit_reload |=> work_q == $past(nv_q))
    else $error("reload did not restore working bytes");

  cmd_read_zero_a: assert property (
    ce && reg_rd && nvc_in_range(reg_addr, ADDR_CMD_COMMIT, ADDR_CMD_RESTART)
    |=> reg_rdata == READ_ZERO)
    else $error("command register read not zero");

  restart_clear_a: assert property (
    hit_restart && (fault_event == '0)
    |=> (fault_flags == '0) && !latched_fault_mode && restart_pulse)
    else $error("restart left a fault recorded");

  rail_write_a: assert property (
    hit_work && (reg_addr == ADDR_WORK_FIRST + 8'(IDX_RAIL_POS))
    |=> positive_rail_level == $past(reg_wdata[LEVEL_W-1:0]))
    else $error("rail setting not taken");

  gate_high_write_a: assert property (
    hit_work && (reg_addr == ADDR_WORK_FIRST + 8'(IDX_GATE_HIGH))
    |=> gate_high_level == $past(reg_wdata[LEVEL_W-1:0]))
    else $error("gate-high setting not taken");

  busy_ignore_a: assert property (
    ce && reg_wr && nvm_busy && (reg_addr == ADDR_CMD_RELOAD)
    |=> $stable(work_q))
    else $error("reload acted during a commit");

  commit_limit_a: assert property (
    hit_commit && limit_hit
    |=> nvm_write_fail_flag && !nvm_busy && $stable(commit_cnt_reg))
    else $error("commit past the lifetime limit");

  copy_length_a: assert property (
    ce && $rose(copy_st) |-> copy_st [*2] ##0 (copy_idx_reg == 4'h1))
    else $error("copy does not step one byte per cycle");

  commit_cov_c:  cover property (commit_go ##1 copy_st);
  reload_cov_c:  cover property (hit_reload);
  restart_cov_c: cover property (latched_fault_mode ##[1:20] hit_restart);
  limit_cov_c:   cover property (hit_commit && limit_hit);
endmodule // nvc_top

// ---- testbench/nvc_host_model.sv ----
`timescale 1ns/10ps
// host side of the register port: strobes change just after falling edges
module nvc_host_model (
  input  wire logic                       mclk,      // system clock
  output logic                            reg_wr,    // write strobe
  output logic                            reg_rd,    // read strobe
  output logic [nvc_pkg::ADDR_W-1:0]      reg_addr,  // register address
  output logic [nvc_pkg::DATA_W-1:0]      reg_wdata, // write data
  input  wire logic [nvc_pkg::DATA_W-1:0] reg_rdata  // read data
);
  import nvc_pkg::*;

  // idle bus at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // one write; released lines show the inverse so a stale value never matches
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk);
    reg_wr    = 1'b1;
    reg_addr  = addr;
    reg_wdata = data;
    @(negedge mclk);
    reg_wr    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask

  // one read; data is registered on the edge that takes the strobe and sampled half a cycle later
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge mclk);
    reg_rd   = 1'b1;
    reg_addr = addr;
    @(negedge mclk);
    reg_rd   = 1'b0;
    reg_addr = ~addr;
    data     = reg_rdata;
  endtask

  // gate-high level with pump choice: doubler instead of tripler sets bit 6
  task automatic set_gate_high(input logic [5:0] lvl, input logic pump);
    write_reg(ADDR_WORK_LAST - 8'h01, {1'b0, pump, lvl});
  endtask
endmodule // nvc_host_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import nvc_pkg::*;
  localparam int unsigned SIM_COMMIT = 20; // short programming time

  logic       mclk, rst_n, ce, vprog_ok, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic [3:0] fault_event, fault_flags;
  logic       latched_fault_mode, restart_pulse, nvm_busy, nvm_write_fail_flag;
  logic [5:0] positive_rail_level, negative_rail_level, gate_high_level, gate_low_level;
  logic       pump_stage_select;
  int         fail_count, cmp_count;
  logic [7:0] ro_addr [5] = '{8'h78, 8'h79, 8'h7A, 8'h25, 8'h50};

  always #25 mclk = ~mclk;

  nvc_host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  nvc_top #(.COMMIT_CYCLES(SIM_COMMIT)) uut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .vprog_ok(vprog_ok), .fault_event(fault_event),
    .fault_flags(fault_flags), .latched_fault_mode(latched_fault_mode),
    .restart_pulse(restart_pulse), .nvm_busy(nvm_busy),
    .nvm_write_fail_flag(nvm_write_fail_flag), .positive_rail_level(positive_rail_level),
    .negative_rail_level(negative_rail_level), .gate_high_level(gate_high_level),
    .gate_low_level(gate_low_level), .pump_stage_select(pump_stage_select));

  // four-state compare, so an unknown never passes
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // bounded wait for the sequencer; a commit needs about 40 cycles here
  task automatic wait_idle;
    int n;
    n = 0;
    while (nvm_busy !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (nvm_busy !== 1'b0) begin
      fail_count++;
      $display("[FAIL] %0t ns: busy never cleared", $time);
      print_verdict();
    end
  endtask

  // a refused commit never raises busy, it only sets the fail flag
  task automatic commit(input logic exp_fail);
    host.write_reg(ADDR_CMD_COMMIT, 8'hA5);
    check({7'h0, nvm_busy}, {7'h0, ~exp_fail});
    wait_idle();
    check({7'h0, nvm_write_fail_flag}, {7'h0, exp_fail});
  endtask

  initial begin
    mclk        = 1'b0;
    rst_n       = 1'b0;
    ce          = 1'b1;
    vprog_ok    = 1'b1;
    fault_event = 4'h0;
    fail_count  = 0;
    cmp_count   = 0;
    repeat (16) @(negedge mclk);
    check({7'h0, nvm_busy}, 8'h01);
    check({2'h0, positive_rail_level}, 8'h00);
    rst_n = 1'b1;
    wait_idle();
    // command registers, store byte and a hole all read zero
    foreach (ro_addr[i]) begin
      host.read_reg(ro_addr[i], rd);
      check(rd, 8'h00);
    end
    // working bytes drive the rails at once
    host.write_reg(ADDR_WORK_FIRST, 8'h5A);
    host.write_reg(8'h13, 8'hAA);
    host.set_gate_high(6'h15, 1'b1);
    host.write_reg(ADDR_WORK_LAST, 8'hFF);
    host.write_reg(ADDR_NV_LAST, 8'h12);
    check({2'h0, positive_rail_level}, 8'h2A);
    check({2'h0, negative_rail_level}, 8'h2A);
    check({2'h0, gate_high_level}, 8'h15);
    check({7'h0, pump_stage_select}, 8'h01);
    check({2'h0, gate_low_level}, 8'h3F);
    host.read_reg(ADDR_NV_LAST, rd);
    check(rd, 8'h00);
    // clock enable low freezes all state, so this write is lost
    ce = 1'b0;
    host.write_reg(8'h13, 8'h3C);
    ce = 1'b1;
    check({2'h0, positive_rail_level}, 8'h2A);
    // commit with zero data; a rail write and a reload are dropped while busy
    host.write_reg(ADDR_CMD_COMMIT, 8'h00);
    check({7'h0, nvm_busy}, 8'h01);
    host.write_reg(8'h13, 8'h01);
    host.write_reg(ADDR_CMD_RELOAD, 8'h00);
    wait_idle();
    check({7'h0, nvm_write_fail_flag}, 8'h00);
    check({2'h0, positive_rail_level}, 8'h2A);
    host.read_reg(ADDR_NV_FIRST, rd);
    check(rd, 8'h5A);
    host.read_reg(8'h23, rd);
    check(rd, 8'hAA);
    host.read_reg(8'h24, rd);
    check(rd, 8'h55);
    host.read_reg(ADDR_NV_LAST, rd);
    check(rd, 8'h3F);
    // reload undoes a later edit
    host.write_reg(8'h13, 8'h11);
    check({2'h0, positive_rail_level}, 8'h11);
    host.write_reg(ADDR_CMD_RELOAD, 8'hC3);
    check({2'h0, positive_rail_level}, 8'h2A);
    host.read_reg(8'h13, rd);
    check(rd, 8'hAA);
    // latch every fault, then restart
    @(negedge mclk);
    fault_event = 4'hF;
    @(negedge mclk);
    fault_event = 4'h0;
    @(negedge mclk);
    check({4'h0, fault_flags}, 8'h0F);
    check({7'h0, latched_fault_mode}, 8'h01);
    host.write_reg(ADDR_CMD_RESTART, 8'h5C);
    check({7'h0, restart_pulse}, 8'h01);
    check({4'h0, fault_flags}, 8'h00);
    @(negedge mclk);
    check({7'h0, latched_fault_mode}, 8'h00);
    check({7'h0, restart_pulse}, 8'h00);
    // a fault in the restart cycle itself stays recorded: set beats clear
    fault_event = 4'h2;
    host.write_reg(ADDR_CMD_RESTART, 8'h00);
    fault_event = 4'h0;
    check({4'h0, fault_flags}, 8'h02);
    check({7'h0, latched_fault_mode}, 8'h01);
    host.write_reg(ADDR_CMD_RESTART, 8'h01);
    check({4'h0, fault_flags}, 8'h00);
    check({7'h0, latched_fault_mode}, 8'h00);
    // supply missing: refused at once, then lost in mid-commit
    vprog_ok = 1'b0;
    commit(1'b1);
    vprog_ok = 1'b1;
    host.write_reg(ADDR_CMD_COMMIT, 8'h3C);
    vprog_ok = 1'b0;
    wait_idle();
    vprog_ok = 1'b1;
    check({7'h0, nvm_write_fail_flag}, 8'h01);
    // the lost commit used a cell write, so four more reach the limit
    repeat (4) commit(1'b0);
    commit(1'b1);
    print_verdict();
  end
endmodule // tb_top
